// >>> exec_tail_map.svh
// Constants for the instruction execution tail: opcodes, registers, field positions and reset values.
`ifndef EXEC_TAIL_MAP_SVH
`define EXEC_TAIL_MAP_SVH

// Operation codes presented on the operation port.
`define OP_NONE          5'h00
`define OP_SET_BYTE      5'h01
`define OP_SET_BIT       5'h02
`define OP_INC_SKIP      5'h03
`define OP_INC_SKIP_ACC  5'h04
`define OP_DEC_SKIP_ACC  5'h05
`define OP_SKIP_BIT_SET  5'h06
`define OP_SUB_MEM       5'h07
`define OP_SUB_TO_MEM    5'h08
`define OP_SUB_IMM       5'h09
`define OP_SWAP          5'h0A
`define OP_SWAP_ACC      5'h0B
`define OP_SKIP_ZERO     5'h0C
`define OP_SKIP_ZERO_MOV 5'h0D
`define OP_SKIP_BIT_CLR  5'h0E
`define OP_TABLE_READ    5'h0F
`define OP_TABLE_LAST    5'h10
`define OP_XOR_MEM       5'h11
`define OP_XOR_TO_MEM    5'h12
`define OP_XOR_IMM       5'h13

// Register map on the software port.
`define REG_ACC          2'h0
`define REG_STATUS       2'h1
`define REG_TBL_PTR      2'h2
`define REG_TBL_HIGH     2'h3

// Status register bit positions.
`define FLAG_C           0
`define FLAG_HALF_CARRY  1
`define FLAG_Z           2
`define FLAG_OVERFLOW    3

// Constants and reset values.
`define BYTE_ONES        8'hFF
`define BYTE_ZERO        8'h00
`define BYTE_ONE         8'h01
`define NIBBLE_MSB       3
`define RESET_BYTE       8'h00

`endif

// >>> exec_tail_pkg.sv
// Types shared by the instruction execution tail.
package exec_tail_pkg;

    // One instruction handed to the core for execution.
    typedef struct packed {
        logic [4:0] opcode;
        logic [2:0] bit_sel;
        logic [7:0] mem_addr;
        logic [7:0] imm;
    } instr_t;

    // Arithmetic status flags.
    typedef struct packed {
        logic overflow_flag;
        logic zero;
        logic half_carry_flag;
        logic c;
    } flags_t;

    // Execution states, Gray coded along the usual path.
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_EXEC  = 2'b01,
        ST_DUMMY = 2'b11,
        ST_TABLE = 2'b10
    } exec_state_t;

endpackage : exec_tail_pkg

// >>> byte_alu.sv
// Combinational byte arithmetic unit: subtract, exclusive-or, step and swap.
`include "exec_tail_map.svh"

module byte_alu #(
    parameter int WIDTH = 8
) (
    // Operands.
    input  wire logic [WIDTH-1:0]        acc,
    input  wire logic [WIDTH-1:0]        operand,
    // Results.
    output logic [WIDTH-1:0]             diff,
    output exec_tail_pkg::flags_t        sub_flags,
    output logic [WIDTH-1:0]             xor_res,
    output logic [WIDTH-1:0]             inc_res,
    output logic [WIDTH-1:0]             dec_res,
    output logic [WIDTH-1:0]             swap_res
);
    logic [WIDTH:0]   wide;
    logic [4:0]       low;

    // Differences wrap modulo the byte, carry is set when no borrow occurs.
    always_comb begin
        wide            = {1'b0, acc} - {1'b0, operand};
        low             = {1'b0, acc[3:0]} - {1'b0, operand[3:0]};
        diff            = wide[WIDTH-1:0];
        sub_flags.c     = ~wide[WIDTH];
        sub_flags.half_carry_flag = ~low[4];
        sub_flags.zero  = (wide[WIDTH-1:0] == '0);
        sub_flags.overflow_flag = (acc[WIDTH-1] ^ operand[WIDTH-1]) & (acc[WIDTH-1] ^ wide[WIDTH-1]);
        xor_res         = acc ^ operand;
        inc_res         = operand + WIDTH'(1);
        dec_res         = operand - WIDTH'(1);
        swap_res        = {operand[`NIBBLE_MSB:0], operand[WIDTH-1:`NIBBLE_MSB+1]};
    end

endmodule : byte_alu

// >>> mcu_instruction_exec_tail.sv
// Execution core for bit set, skip, subtract, swap, exclusive-or and table read instructions.
`include "exec_tail_map.svh"

module mcu_instruction_exec_tail #(
    parameter int MEM_DEPTH  = 256,
    parameter int PROG_WIDTH = 16,
    parameter int PROG_ADDR  = 16,
    parameter int HIGH_BITS  = 8
) (
    // Clock and reset.
    input  wire logic                     clock,
    input  wire logic                     arst_n,
    // Instruction issue.
    input  wire logic                     instr_valid,
    input  wire exec_tail_pkg::instr_t    instr,
    output logic                          instr_ready_reg,
    output logic                          skip_next_reg,
    output logic                          done_reg,
    // Program memory port for table reads.
    output logic [PROG_ADDR-1:0]          prog_addr_reg,
    output logic                          prog_rd_reg,
    input  wire logic [PROG_WIDTH-1:0]    prog_data,
    // Software register port.
    input  wire logic [1:0]               sw_addr,
    input  wire logic [15:0]              sw_wdata,
    input  wire logic                     sw_wr,
    input  wire logic                     sw_rd,
    output logic [15:0]                   sw_rdata_reg,
    // Data memory debug read.
    input  wire logic [7:0]               dbg_addr,
    output logic [7:0]                    dbg_data_reg
);
    localparam logic [PROG_ADDR-1:0] LAST_PAGE = {{(PROG_ADDR-8){1'b1}}, 8'h00};

    exec_tail_pkg::exec_state_t state_reg;
    exec_tail_pkg::instr_t      cur_reg;
    exec_tail_pkg::flags_t      flags_reg;
    logic [7:0]                 acc_reg;
    logic [7:0]                 table_pointer_low_reg;
    logic [HIGH_BITS-1:0]       table_pointer_high_reg;
    logic [7:0]                 table_high_latch_reg;
    logic [7:0]                 dmem [MEM_DEPTH];

    logic [7:0]                 mem_val;
    logic [7:0]                 diff;
    logic [7:0]                 xor_res;
    logic [7:0]                 inc_res;
    logic [7:0]                 dec_res;
    logic [7:0]                 swap_res;
    exec_tail_pkg::flags_t      sub_flags;
    logic [7:0]                 sub_rhs;
    logic [7:0]                 xor_rhs;
    logic [7:0]                 alu_operand;
    logic                       mem_we;
    logic [7:0]                 mem_wdata;
    logic                       acc_we;
    logic [7:0]                 acc_wdata;
    logic                       flags_we;
    exec_tail_pkg::flags_t      flags_wdata;
    logic                       skip;
    logic                       is_exec;
    logic                       is_table;

    // True when the operation draws on the immediate field instead of memory.
    function automatic logic uses_imm(input logic [4:0] op);
        return (op == `OP_SUB_IMM) || (op == `OP_XOR_IMM);
    endfunction : uses_imm

    // Byte with one bit forced high.
    function automatic logic [7:0] bit_mask(input logic [2:0] sel);
        return `BYTE_ONE << sel;
    endfunction : bit_mask

    assign mem_val   = dmem[cur_reg.mem_addr];
    assign is_exec   = (state_reg == exec_tail_pkg::ST_EXEC);
    assign is_table  = (state_reg == exec_tail_pkg::ST_TABLE);
    assign sub_rhs   = uses_imm(cur_reg.opcode) ? cur_reg.imm : mem_val;
    assign xor_rhs   = sub_rhs;
    assign alu_operand = (cur_reg.opcode == `OP_XOR_MEM || cur_reg.opcode == `OP_XOR_TO_MEM ||
                          cur_reg.opcode == `OP_XOR_IMM) ? xor_rhs : sub_rhs;

    byte_alu #(
        .WIDTH     (8)
    ) u_alu (
        .acc       (acc_reg),
        .operand   (alu_operand),
        .diff      (diff),
        .sub_flags (sub_flags),
        .xor_res   (xor_res),
        .inc_res   (inc_res),
        .dec_res   (dec_res),
        .swap_res  (swap_res)
    );

    // Decode the current operation into write enables, values and skip decision.
    always_comb begin
        mem_we      = 1'b0;
        mem_wdata   = mem_val;
        acc_we      = 1'b0;
        acc_wdata   = acc_reg;
        flags_we    = 1'b0;
        flags_wdata = flags_reg;
        skip        = 1'b0;
        case (cur_reg.opcode)
            `OP_SET_BYTE: begin
                mem_we    = 1'b1;
                mem_wdata = `BYTE_ONES;
            end
            `OP_SET_BIT: begin
                mem_we    = 1'b1;
                mem_wdata = mem_val | bit_mask(cur_reg.bit_sel);
            end
            `OP_INC_SKIP: begin
                mem_we    = 1'b1;
                mem_wdata = inc_res;
                skip      = (inc_res == `BYTE_ZERO);
            end
            `OP_INC_SKIP_ACC: begin
                acc_we    = 1'b1;
                acc_wdata = inc_res;
                skip      = (inc_res == `BYTE_ZERO);
            end
            `OP_DEC_SKIP_ACC: begin
                acc_we    = 1'b1;
                acc_wdata = dec_res;
                skip      = (dec_res == `BYTE_ZERO);
            end
            `OP_SKIP_BIT_SET: begin
                skip      = mem_val[cur_reg.bit_sel];
            end
            `OP_SUB_MEM, `OP_SUB_IMM: begin
                acc_we      = 1'b1;
                acc_wdata   = diff;
                flags_we    = 1'b1;
                flags_wdata = sub_flags;
            end
            `OP_SUB_TO_MEM: begin
                mem_we      = 1'b1;
                mem_wdata   = diff;
                flags_we    = 1'b1;
                flags_wdata = sub_flags;
            end
            `OP_SWAP: begin
                mem_we    = 1'b1;
                mem_wdata = swap_res;
            end
            `OP_SWAP_ACC: begin
                acc_we    = 1'b1;
                acc_wdata = swap_res;
            end
            `OP_SKIP_ZERO: begin
                mem_we    = 1'b1;
                mem_wdata = mem_val;
                skip      = (mem_val == `BYTE_ZERO);
            end
            `OP_SKIP_ZERO_MOV: begin
                acc_we    = 1'b1;
                acc_wdata = mem_val;
                skip      = (mem_val == `BYTE_ZERO);
            end
            `OP_SKIP_BIT_CLR: begin
                skip      = ~mem_val[cur_reg.bit_sel];
            end
            `OP_XOR_MEM, `OP_XOR_IMM: begin
                acc_we           = 1'b1;
                acc_wdata        = xor_res;
                flags_we         = 1'b1;
                flags_wdata.zero = (xor_res == `BYTE_ZERO);
            end
            `OP_XOR_TO_MEM: begin
                mem_we           = 1'b1;
                mem_wdata        = xor_res;
                flags_we         = 1'b1;
                flags_wdata.zero = (xor_res == `BYTE_ZERO);
            end
            default: begin
                skip = 1'b0;
            end
        endcase
    end

    // Sequencer: plain instructions take one cycle, skips add a dummy, table reads wait for program data.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= exec_tail_pkg::ST_IDLE;
            cur_reg   <= '0;
        end else begin
            case (state_reg)
                exec_tail_pkg::ST_IDLE: begin
                    if (instr_valid) begin
                        cur_reg   <= instr;
                        state_reg <= exec_tail_pkg::ST_EXEC;
                    end
                end
                exec_tail_pkg::ST_EXEC: begin
                    if (cur_reg.opcode == `OP_TABLE_READ || cur_reg.opcode == `OP_TABLE_LAST) begin
                        state_reg <= exec_tail_pkg::ST_TABLE;
                    end else if (skip) begin
                        state_reg <= exec_tail_pkg::ST_DUMMY;
                    end else begin
                        state_reg <= exec_tail_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= exec_tail_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Handshake and completion pulses; the dummy cycle is the one the skipped instruction would have used.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            instr_ready_reg <= 1'b1;
            done_reg        <= 1'b0;
            skip_next_reg   <= 1'b0;
        end else begin
            instr_ready_reg <= (state_reg == exec_tail_pkg::ST_IDLE) ? !instr_valid
                             : (is_exec && !skip && cur_reg.opcode != `OP_TABLE_READ &&
                                cur_reg.opcode != `OP_TABLE_LAST) || state_reg == exec_tail_pkg::ST_DUMMY
                             || is_table;
            done_reg        <= (is_exec && !skip && cur_reg.opcode != `OP_TABLE_READ &&
                                cur_reg.opcode != `OP_TABLE_LAST) ||
                               state_reg == exec_tail_pkg::ST_DUMMY || is_table;
            skip_next_reg   <= is_exec && skip;
        end
    end

    // Program address is formed in the execute cycle so data are back in the following one.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            prog_addr_reg <= '0;
            prog_rd_reg   <= 1'b0;
        end else begin
            prog_rd_reg <= is_exec && (cur_reg.opcode == `OP_TABLE_READ || cur_reg.opcode == `OP_TABLE_LAST);
            if (is_exec && cur_reg.opcode == `OP_TABLE_LAST) begin
                prog_addr_reg <= LAST_PAGE | PROG_ADDR'(table_pointer_low_reg);
            end else if (is_exec) begin
                prog_addr_reg <= PROG_ADDR'({table_pointer_high_reg, table_pointer_low_reg});
            end
        end
    end

    // Accumulator: instruction results, else software writes.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            acc_reg <= `RESET_BYTE;
        end else if (is_exec && acc_we) begin
            acc_reg <= acc_wdata;
        end else if (sw_wr && sw_addr == `REG_ACC) begin
            acc_reg <= sw_wdata[7:0];
        end
    end

    // Status flags change only for the arithmetic and logic operations, else on software writes.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            flags_reg <= '0;
        end else if (is_exec && flags_we) begin
            flags_reg <= flags_wdata;
        end else if (sw_wr && sw_addr == `REG_STATUS) begin
            flags_reg <= sw_wdata[`FLAG_OVERFLOW:`FLAG_C];
        end
    end

    // Table pointers are software written; the high latch takes the upper program byte.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            table_pointer_low_reg  <= `RESET_BYTE;
            table_pointer_high_reg <= '0;
            table_high_latch_reg   <= `RESET_BYTE;
        end else begin
            if (sw_wr && sw_addr == `REG_TBL_PTR) begin
                table_pointer_low_reg  <= sw_wdata[7:0];
                table_pointer_high_reg <= sw_wdata[8 +: HIGH_BITS];
            end
            if (is_table) begin
                table_high_latch_reg <= prog_data[15:8];
            end
        end
    end

    // Data memory has no reset; it is the on-chip RAM array.
    always_ff @(posedge clock) begin
        if (is_exec && mem_we) begin
            dmem[cur_reg.mem_addr] <= mem_wdata;
        end else if (is_table) begin
            dmem[cur_reg.mem_addr] <= prog_data[7:0];
        end
    end

    // Software read data, one cycle after the strobe; debug view of memory.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sw_rdata_reg <= '0;
            dbg_data_reg <= `RESET_BYTE;
        end else begin
            dbg_data_reg <= dmem[dbg_addr];
            if (!sw_rd) begin
                sw_rdata_reg <= '0;
            end else if (sw_addr == `REG_ACC) begin
                sw_rdata_reg <= {8'h00, acc_reg};
            end else if (sw_addr == `REG_STATUS) begin
                sw_rdata_reg <= {12'h000, flags_reg};
            end else if (sw_addr == `REG_TBL_PTR) begin
                sw_rdata_reg <= 16'({table_pointer_high_reg, table_pointer_low_reg});
            end else begin
                sw_rdata_reg <= {8'h00, table_high_latch_reg};
            end
        end
    end

    // Checks next to the logic.
    sequence s_skip_exec;
        is_exec && skip;
    endsequence

    a_skip_dummy_cycle: assert property (@(posedge clock) disable iff (!arst_n)
        s_skip_exec |=> state_reg == exec_tail_pkg::ST_DUMMY ##1 done_reg)
        else $error("Skip did not insert dummy cycle.");
    a_plain_one_cycle: assert property (@(posedge clock) disable iff (!arst_n)
        (is_exec && !skip && cur_reg.opcode == `OP_XOR_MEM) |=> done_reg && state_reg == exec_tail_pkg::ST_IDLE)
        else $error("Plain instruction not done in one cycle.");
    a_set_byte_ones: assert property (@(posedge clock) disable iff (!arst_n)
        (is_exec && cur_reg.opcode == `OP_SET_BYTE) |=> dmem[$past(cur_reg.mem_addr)] == `BYTE_ONES && $stable(flags_reg))
        else $error("Set byte wrong.");
    a_sub_carry_flag: assert property (@(posedge clock) disable iff (!arst_n)
        (is_exec && cur_reg.opcode == `OP_SUB_MEM) |=> flags_reg.c == ($past(acc_reg) >= $past(mem_val)))
        else $error("Subtract carry wrong.");
    a_sub_acc_value: assert property (@(posedge clock) disable iff (!arst_n)
        (is_exec && cur_reg.opcode == `OP_SUB_IMM) |=> acc_reg == 8'($past(acc_reg) - $past(cur_reg.imm)))
        else $error("Subtract immediate wrong.");
    a_xor_zero_only: assert property (@(posedge clock) disable iff (!arst_n)
        (is_exec && cur_reg.opcode == `OP_XOR_MEM) |=> flags_reg.c == $past(flags_reg.c) &&
        flags_reg.zero == (acc_reg == `BYTE_ZERO))
        else $error("Exclusive-or flags wrong.");
    a_inc_acc_skip: assert property (@(posedge clock) disable iff (!arst_n)
        (is_exec && cur_reg.opcode == `OP_INC_SKIP_ACC && mem_val == `BYTE_ONES) |=> skip_next_reg && acc_reg == `BYTE_ZERO)
        else $error("Increment skip wrong.");
    a_bit_clear_skip: assert property (@(posedge clock) disable iff (!arst_n)
        (is_exec && cur_reg.opcode == `OP_SKIP_BIT_CLR) |=> skip_next_reg == !$past(mem_val[cur_reg.bit_sel]))
        else $error("Bit clear skip wrong.");
    a_table_latch: assert property (@(posedge clock) disable iff (!arst_n)
        is_table |=> table_high_latch_reg == $past(prog_data[15:8]))
        else $error("Table high latch wrong.");

endmodule : mcu_instruction_exec_tail

// >>> prog_rom_model.sv
// Behavioural program memory that answers table reads from the execution core.
module prog_rom_model (
    // Clock.
    input  wire logic        clock,
    // Read request from the core.
    input  wire logic [15:0] prog_addr_reg,
    input  wire logic        prog_rd_reg,
    // Word returned.
    output logic [15:0]      prog_data
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] filler = 16'h5A5A;

    // Outside the answer cycle a toggling filler stands, so stale data is never mistaken for a hit.
    always @(posedge clock) begin
        filler <= ~filler;
    end

    // The core samples the word at the edge that ends its read pulse, so the word stands while the pulse does.
    // Word contents follow the address, so a wrong page or pointer gives a wrong word.
    assign prog_data = prog_rd_reg ? {~prog_addr_reg[7:0], prog_addr_reg[15:8]} : filler;
endmodule : prog_rom_model

// >>> mcu_instruction_exec_tail_bench.sv
// Self-checking bench for the instruction execution tail.
`include "exec_tail_map.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module mcu_instruction_exec_tail_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, arst_n = 0, instr_valid = 0, sw_wr = 0, sw_rd = 0;
    exec_tail_pkg::instr_t instr = '0;
    logic [1:0] sw_addr = '0;
    logic [15:0] sw_wdata = '0, sw_rdata_reg, prog_addr_reg, prog_data;
    logic [7:0] dbg_addr = '0, dbg_data_reg;
    logic instr_ready_reg, skip_next_reg, done_reg, prog_rd_reg;
    int err_total = 0, tests_run = 0;
    always #25 clock = ~clock;
    mcu_instruction_exec_tail u_mcu_instruction_exec_tail (.clock(clock), .arst_n(arst_n),
        .instr_valid(instr_valid), .instr(instr), .instr_ready_reg(instr_ready_reg),
        .skip_next_reg(skip_next_reg), .done_reg(done_reg), .prog_addr_reg(prog_addr_reg),
        .prog_rd_reg(prog_rd_reg), .prog_data(prog_data), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
        .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata_reg(sw_rdata_reg), .dbg_addr(dbg_addr),
        .dbg_data_reg(dbg_data_reg));
    prog_rom_model u_prog_rom_model (.clock(clock), .prog_addr_reg(prog_addr_reg),
        .prog_rd_reg(prog_rd_reg), .prog_data(prog_data));
    task end_of_test;
        if (err_total == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_of_test
    // Issue one instruction and judge its length in cycles and its skip pulse.
    task ex(input logic [4:0] op, input logic [2:0] b, input logic [7:0] a, input logic [7:0] im,
            input logic sk, input int n);
        int k;
        logic s;
        s = 0;
        @(posedge clock);
        instr_valid <= 1;
        instr <= {op, b, a, im};
        @(posedge clock);
        instr_valid <= 0;
        for (k = 2; k < 10; k++) begin
            @(posedge clock);
            #1 s |= skip_next_reg;
            if (done_reg === 1'b1) break;
        end
        `CHK("cycles", n, k)
        `CHK("skip", sk, s)
        `CHK("ready", 1'b1, instr_ready_reg)
        if (k == 10) end_of_test();
    endtask : ex
    task wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge clock);
        sw_wr <= 1; sw_addr <= a; sw_wdata <= d;
        @(posedge clock);
        sw_wr <= 0;
    endtask : wr
    // Read data stand only in the cycle after the strobe.
    task rd(input logic [1:0] a, input logic [15:0] e);
        @(posedge clock);
        sw_rd <= 1; sw_addr <= a;
        @(posedge clock);
        sw_rd <= 0;
        #1 `CHK("register", e, sw_rdata_reg)
    endtask : rd
    task mem(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        dbg_addr <= a;
        @(posedge clock);
        #1 `CHK("memory", e, dbg_data_reg)
    endtask : mem
    // Data memory has no reset, so a byte is built from all ones and an exclusive-or.
    task poke(input logic [7:0] a, input logic [7:0] d);
        ex(`OP_SET_BYTE, 0, a, 0, 0, 2);
        wr(`REG_ACC, {8'h00, d ^ 8'hFF});
        ex(`OP_XOR_TO_MEM, 0, a, 0, 0, 2);
    endtask : poke
    task sc_set;
        wr(`REG_STATUS, 16'h000A);
        ex(`OP_SET_BYTE, 0, 8'h10, 0, 0, 2);
        mem(8'h10, 8'hFF);
        poke(8'h11, 8'h00);
        wr(`REG_STATUS, 16'h000A);
        ex(`OP_SET_BIT, 5, 8'h11, 0, 0, 2);
        mem(8'h11, 8'h20);
        rd(`REG_STATUS, 16'h000A);
    endtask : sc_set
    task sc_step;
        poke(8'h12, 8'hFF);
        ex(`OP_INC_SKIP, 0, 8'h12, 0, 1, 3);
        mem(8'h12, 8'h00);
        ex(`OP_INC_SKIP, 0, 8'h12, 0, 0, 2);
        mem(8'h12, 8'h01);
        poke(8'h13, 8'hFF);
        ex(`OP_INC_SKIP_ACC, 0, 8'h13, 0, 1, 3);
        rd(`REG_ACC, 16'h0000);
        mem(8'h13, 8'hFF);
        poke(8'h14, 8'h01);
        ex(`OP_DEC_SKIP_ACC, 0, 8'h14, 0, 1, 3);
        mem(8'h14, 8'h01);
        poke(8'h14, 8'h00);
        ex(`OP_DEC_SKIP_ACC, 0, 8'h14, 0, 0, 2);
        rd(`REG_ACC, 16'h00FF);
    endtask : sc_step
    task sc_bits;
        poke(8'h15, 8'h20);
        ex(`OP_SKIP_BIT_SET, 5, 8'h15, 0, 1, 3);
        ex(`OP_SKIP_BIT_SET, 4, 8'h15, 0, 0, 2);
        ex(`OP_SKIP_BIT_CLR, 4, 8'h15, 0, 1, 3);
        ex(`OP_SKIP_BIT_CLR, 5, 8'h15, 0, 0, 2);
        mem(8'h15, 8'h20);
    endtask : sc_bits
    task sc_sub;
        poke(8'h16, 8'h20);
        wr(`REG_ACC, 16'h0010);
        ex(`OP_SUB_MEM, 0, 8'h16, 0, 0, 2);
        rd(`REG_ACC, 16'h00F0);
        rd(`REG_STATUS, 16'h0002);
        wr(`REG_ACC, 16'h0080);
        ex(`OP_SUB_IMM, 0, 0, 8'h01, 0, 2);
        rd(`REG_ACC, 16'h007F);
        rd(`REG_STATUS, 16'h0009);
        poke(8'h17, 8'h33);
        wr(`REG_ACC, 16'h0033);
        ex(`OP_SUB_TO_MEM, 0, 8'h17, 0, 0, 2);
        mem(8'h17, 8'h00);
        rd(`REG_STATUS, 16'h0007);
        rd(`REG_ACC, 16'h0033);
    endtask : sc_sub
    task sc_swap_zero;
        poke(8'h18, 8'hA5);
        wr(`REG_STATUS, 16'h0006);
        ex(`OP_SWAP, 0, 8'h18, 0, 0, 2);
        mem(8'h18, 8'h5A);
        ex(`OP_SWAP_ACC, 0, 8'h18, 0, 0, 2);
        rd(`REG_ACC, 16'h00A5);
        mem(8'h18, 8'h5A);
        rd(`REG_STATUS, 16'h0006);
        poke(8'h19, 8'h00);
        wr(`REG_STATUS, 16'h0005);
        ex(`OP_SKIP_ZERO, 0, 8'h19, 0, 1, 3);
        mem(8'h19, 8'h00);
        ex(`OP_SKIP_ZERO_MOV, 0, 8'h18, 0, 0, 2);
        rd(`REG_ACC, 16'h005A);
        rd(`REG_STATUS, 16'h0005);
    endtask : sc_swap_zero
    task sc_xor;
        wr(`REG_STATUS, 16'h0009);
        ex(`OP_XOR_MEM, 0, 8'h18, 0, 0, 2);
        rd(`REG_ACC, 16'h0000);
        rd(`REG_STATUS, 16'h000D);
        ex(`OP_XOR_IMM, 0, 0, 8'h0F, 0, 2);
        rd(`REG_STATUS, 16'h0009);
        ex(`OP_XOR_TO_MEM, 0, 8'h18, 0, 0, 2);
        mem(8'h18, 8'h55);
        rd(`REG_ACC, 16'h000F);
    endtask : sc_xor
    // The last page must ignore the high pointer byte and use all-ones above the low byte.
    task sc_table;
        wr(`REG_TBL_PTR, 16'h1234);
        ex(`OP_TABLE_READ, 0, 8'h1A, 0, 0, 3);
        mem(8'h1A, 8'h12);
        rd(`REG_TBL_HIGH, 16'h00CB);
        wr(`REG_TBL_PTR, 16'h1277);
        ex(`OP_TABLE_LAST, 0, 8'h1B, 0, 0, 3);
        mem(8'h1B, 8'hFF);
        rd(`REG_TBL_HIGH, 16'h0088);
    endtask : sc_table
    // Main sequence: reset, then every scenario in turn.
    initial begin
        repeat (16) @(posedge clock);
        arst_n <= 1;
        rd(`REG_ACC, 16'h0000);
        rd(`REG_STATUS, 16'h0000);
        sc_set();
        sc_step();
        sc_bits();
        sc_sub();
        sc_swap_zero();
        sc_xor();
        sc_table();
        end_of_test();
    end
endmodule : mcu_instruction_exec_tail_bench
